// ---- rtl/sramc_pkg.sv ----
// Constants, timing figures and carrier types for the static memory controller.
// Assumes a single 10 MHz clock; all memory pins are sampled or driven on it.
// Notes on behaviour
// - Address changes on the same edge as the write starts, with zero setup.
// - Select and we low together long enough.
// - Select asserted long enough before write end.
// - Address valid long enough before write end.
// - Data may go at the write end.
// - Controller never fights memory driving data.
package sramc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 100;
    // Slowest grade figures, so every grade is met
    localparam int T_ACCESS_NS = 120;
    localparam int T_OE_ACCESS_NS = 60;
    localparam int T_FLOAT_NS = 40;
    localparam int T_WRITE_NS = 90;
    localparam int T_CS_END_NS = 100;
    localparam int T_DSETUP_NS = 50;
    localparam int T_RECOVER_NS = 10;
    localparam int T_WX_NS = 15;
    // Least times round up, at least one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RD_CYC = cyc_up(T_ACCESS_NS);
    localparam int WR_CYC = cyc_up(T_CS_END_NS > T_WRITE_NS ? T_CS_END_NS : T_WRITE_NS);
    localparam int REC_CYC = cyc_up(T_RECOVER_NS > T_FLOAT_NS ? T_RECOVER_NS : T_FLOAT_NS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sramc_req_type;

    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
    } sramc_pins_type;
endpackage

// ---- rtl/sramc_timer.sv ----
// Down counter that marks the end of a timed memory phase.
// Assumes load and start never coincide with a running count being needed.
`timescale 1ns/1ps
`default_nettype none
module sramc_timer #(
    parameter int W = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // Load wins over counting down
    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = count;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - W'(1);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // High on the last cycle of a phase
    assign done = (cnt_ff == W'(1));
endmodule
`default_nettype wire

// ---- rtl/sramc_ctrl.sv ----
// Host-side controller for an asynchronous 32K x 8 static memory.
// Turns single byte requests into timed select, strobe and address phases.
// Assumes memory pins are sampled on the 10 MHz clock and the data bus
// is resolved outside from mem_data_oe.
// Phase lengths are whole cycles, so a faster clock needs new counts.
`timescale 1ns/1ps
`default_nettype none
module sramc_ctrl #(
    parameter int ADDR_W = sramc_pkg::ADDR_W,
    parameter int DATA_W = sramc_pkg::DATA_W
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input wire sramc_pkg::sramc_req_type req,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    output logic mem_cs_n,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_READ,
        S_WRITE,
        S_RECOVER
    } sramc_state_type;

    // Sequencer state and phase timer hookup
    sramc_state_type state_ff;
    sramc_state_type nxt_state;
    logic tmr_load;
    logic [sramc_pkg::CNT_W-1:0] tmr_count;
    logic tmr_done;

    // Memory strobes and address
    sramc_pkg::sramc_pins_type pins_ff;
    sramc_pkg::sramc_pins_type nxt_pins;

    // Write data path toward the shared bus
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] nxt_wdata;
    logic data_oe_ff;
    logic nxt_data_oe;

    // Read answer
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic rsp_valid_ff;
    logic nxt_rsp_valid;

    // Phase events decoded once from request, state and timer
    logic take_req;
    logic take_write;
    logic take_read;
    logic read_end;
    logic write_end;
    logic recover_end;

    // Phase length timer
    sramc_timer #(
        .W(sramc_pkg::CNT_W)
    ) u_timer (
        .clock(clock),
        .resetn(resetn),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Requests taken only when the bus is quiet and recovered
    assign req_ready = (state_ff == S_IDLE);

    // Phase events shared by the pin, data and answer groups
    assign take_req = req_valid && req_ready;
    assign take_write = take_req && req.write;
    assign take_read = take_req && !req.write;
    assign read_end = (state_ff == S_READ) && tmr_done;
    assign write_end = (state_ff == S_WRITE) && tmr_done;
    assign recover_end = (state_ff == S_RECOVER) && tmr_done;

    // Sequencer: one access at a time, phases timed by the down counter
    always_comb begin
        nxt_state = state_ff;
        tmr_load = 1'b0;
        tmr_count = sramc_pkg::CNT_ZERO;
        case (state_ff)
            S_IDLE: begin
                if (take_write) begin
                    tmr_load = 1'b1;
                    tmr_count = sramc_pkg::CNT_W'(sramc_pkg::WR_CYC);
                    nxt_state = S_WRITE;
                end else if (take_read) begin
                    tmr_load = 1'b1;
                    tmr_count = sramc_pkg::CNT_W'(sramc_pkg::RD_CYC);
                    nxt_state = S_READ;
                end
            end
            S_READ: begin
                // Full access time passes before the sample is taken
                if (read_end) begin
                    tmr_load = 1'b1;
                    tmr_count = sramc_pkg::CNT_W'(sramc_pkg::REC_CYC);
                    nxt_state = S_RECOVER;
                end
            end
            S_WRITE: begin
                // Overlap lasts long enough for write, select and address
                if (write_end) begin
                    tmr_load = 1'b1;
                    tmr_count = sramc_pkg::CNT_W'(sramc_pkg::REC_CYC);
                    nxt_state = S_RECOVER;
                end
            end
            S_RECOVER: begin
                // Memory float time absorbed before the next select
                if (recover_end) begin
                    nxt_state = S_IDLE;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Strobes and address; the address stays put through recovery
    always_comb begin
        nxt_pins = pins_ff;
        if (take_req) begin
            // Address settles with select, zero setup suffices
            nxt_pins.addr = req.addr[ADDR_W-1:0];
            nxt_pins.cs_n = 1'b0;
            nxt_pins.we_n = !req.write;
            nxt_pins.oe_n = req.write;
        end else if (read_end || write_end) begin
            // Both strobes end on the same edge as select
            nxt_pins.cs_n = 1'b1;
            nxt_pins.we_n = 1'b1;
            nxt_pins.oe_n = 1'b1;
        end
    end

    // Reset parks the memory deselected, bus released
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pins_ff <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
        end else begin
            pins_ff <= nxt_pins;
        end
    end

    // Write data launched with the strobes, held one cycle past the write end
    always_comb begin
        nxt_wdata = wdata_ff;
        nxt_data_oe = data_oe_ff;
        if (take_write) begin
            nxt_wdata = req.wdata[DATA_W-1:0];
            nxt_data_oe = 1'b1;
        end else if (take_read || (state_ff == S_RECOVER)) begin
            // Never drive while the memory may be driving
            nxt_data_oe = 1'b0;
        end
    end

    // Write data registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wdata_ff <= '0;
            data_oe_ff <= 1'b0;
        end else begin
            wdata_ff <= nxt_wdata;
            data_oe_ff <= nxt_data_oe;
        end
    end

    // Read byte taken on the last access edge; the answer pulses once
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_rsp_valid = 1'b0;
        if (read_end) begin
            nxt_rdata = mem_data_in;
            nxt_rsp_valid = 1'b1;
        end
    end

    // Read answer registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= '0;
            rsp_valid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rsp_valid_ff <= nxt_rsp_valid;
        end
    end

    // All pin outputs come straight from flip-flops
    assign mem_cs_n = pins_ff.cs_n;
    assign mem_we_n = pins_ff.we_n;
    assign mem_oe_n = pins_ff.oe_n;
    assign mem_addr = pins_ff.addr[ADDR_W-1:0];
    assign mem_data_out = wdata_ff;
    assign mem_data_oe = data_oe_ff;

    // Answer to the host comes from flip-flops too
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rdata_ff;
endmodule
`default_nettype wire

// ---- sim/sramc_ctrl_sva.sv ----
// Port assertions for the static memory controller.
// Bound into the controller from the bench top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sramc_ctrl_sva (
    input wire logic clock,
    input wire logic resetn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire sramc_pkg::sramc_req_type req,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic mem_cs_n,
    input wire logic mem_we_n,
    input wire logic mem_oe_n,
    input wire logic [14:0] mem_addr,
    input wire logic [7:0] mem_data_in,
    input wire logic [7:0] mem_data_out,
    input wire logic mem_data_oe
);
    wire logic tk = req_valid && req_ready;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Strobe shapes per transfer kind
    AST_RD_PINS: assert property (tk && !req.write |=> (!mem_cs_n && !mem_oe_n && mem_we_n)[*2]
        ##1 (mem_cs_n && mem_oe_n)) else $error("read strobes wrong");
    AST_WR_PINS: assert property (tk && req.write |=>
        (!mem_cs_n && !mem_we_n && mem_data_oe) ##1 (mem_cs_n && mem_we_n && mem_data_oe)
        ##1 !mem_data_oe) else $error("write strobes wrong");
    AST_ADDR: assert property (tk |=> mem_addr == $past(req.addr))
        else $error("address not from request");
    AST_WDATA: assert property (tk && req.write |=> mem_data_out == $past(req.wdata))
        else $error("write data not from request");
    AST_ADDR_HOLD: assert property ($rose(mem_cs_n) |-> $stable(mem_addr) ##1 $stable(mem_addr))
        else $error("address moved in recovery");
    AST_NO_FIGHT: assert property (mem_data_oe |-> mem_oe_n)
        else $error("bus driven during read");
    AST_RSP: assert property (tk && !req.write |-> ##3 rsp_valid ##1 !rsp_valid)
        else $error("read answer late or long");
    AST_RDATA: assert property (rsp_valid |-> rsp_data == $past(mem_data_in))
        else $error("read data not sampled bus");
    AST_READY_RD: assert property (tk && !req.write |=> !req_ready[*3] ##1 req_ready)
        else $error("read ready spacing wrong");
    AST_READY_WR: assert property (tk && req.write |=> !req_ready[*2] ##1 req_ready)
        else $error("write ready spacing wrong");
    AST_TURN: assert property ($rose(mem_oe_n) |-> !mem_data_oe)
        else $error("bus driven as read ends");
endmodule
`default_nettype wire

// ---- sim/sramc_mem.sv ----
// Behavioural 32K x 8 static memory on the controller's pins.
// Assumes the bench resolves the shared data bus into mem_data_in.
`timescale 1ns/1ps
`default_nettype none
module sramc_mem #(
    parameter int ACC_NS = 120
) (
    input wire logic mem_cs_n,
    input wire logic mem_we_n,
    input wire logic mem_oe_n,
    input wire logic [14:0] mem_addr,
    input wire logic [7:0] mem_data_in,
    output wire logic [7:0] mem_q
);
    logic [7:0] cells [32768];
    wire logic rd_on = !mem_cs_n && !mem_oe_n && mem_we_n;
    wire logic wr_on = !mem_cs_n && !mem_we_n;
    // Floating bus shows the inverse, so an early sample never matches; a late one up to ACC_NS after the read ends still does
    assign #(ACC_NS) mem_q = rd_on ? cells[mem_addr] : ~cells[mem_addr];
    // Store at the end of the overlap; zero hold is enough
    always @(negedge wr_on) begin
        cells[mem_addr] = mem_data_in;
    end
endmodule
`default_nettype wire

// ---- sim/sramc_tb_top.sv ----
// Self-checking bench: controller, memory model and a reference byte map.
// Assumes the package, controller, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sramc_tb_top;
    logic clock, resetn, req_valid, req_ready, rsp_valid;
    logic mem_cs_n, mem_we_n, mem_oe_n, mem_data_oe;
    sramc_pkg::sramc_req_type req;
    logic [7:0] rsp_data, mem_data_out, mem_data_in;
    wire logic [7:0] mem_q;
    logic [14:0] mem_addr;
    int n_fail, tests_run;
    byte unsigned ref_mem [int];
    logic [14:0] pool [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h5555};
    assign mem_data_in = mem_data_oe ? mem_data_out : mem_q;
    sramc_ctrl sramc_ctrl_i (.*);
    sramc_mem sramc_mem_i (.*);
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One request; bounded waits, a hang counts as a mismatch
    task automatic op(logic wr, logic [14:0] a, logic [7:0] d);
        int k;
        k = 0;
        req_valid = 1'b1;
        req = '{wr, a, d};
        while (req_ready !== 1'b1) begin
            @(posedge clock);
            #1;
            if (++k > 20) begin n_fail++; finish_test(); end
        end
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        if (wr) ref_mem[a] = d;
        k = 0;
        while (!wr && rsp_valid !== 1'b1) begin
            @(posedge clock);
            #1;
            if (++k > 8) begin n_fail++; finish_test(); end
        end
        if (!wr) check("rd_lat", 8'(k), 8'(sramc_pkg::RD_CYC));
        if (!wr) check("rsp_data", rsp_data, ref_mem[a]);
        // Let an edge pass so the next call does not raise valid in this step
        if (wr) begin
            @(posedge clock);
            #1;
        end
    endtask
    initial begin
        n_fail = 0;
        tests_run = 0;
        resetn = 0;
        req_valid = 0;
        req = '0;
        void'($urandom(32'h53e069df));
        repeat (20) @(posedge clock);
        #1 resetn = 1;
        check("idle pins", {5'h00, mem_cs_n, mem_we_n, mem_oe_n}, 8'h07);
        foreach (pool[i]) op(1'b1, pool[i], 8'(i) ^ 8'ha5);
        repeat (60) op(1'($urandom), pool[$urandom % 4], 8'($urandom));
        finish_test();
    end
endmodule
bind sramc_ctrl sramc_ctrl_sva sramc_ctrl_sva_i (.*);
`default_nettype wire
